// ---- dv/masked_rom_access_control_properties.sv ----
// Port-level assertions for the masked ROM control block
`timescale 1ns/1ps
module masked_rom_access_control_properties
  import rom_module_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic MASK_BOOT = 1'b0,
  parameter logic [15:0] MASK_SIG_HIGH = 16'h1234,
  parameter logic [63:0] MASK_BOOT_WORDS = 64'h0,
  parameter logic [23:0] REG_BLOCK_BASE = 24'hfff820
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Array and vector ports
  input wire logic arr_req,
  input wire logic [23:0] arr_addr,
  input wire logic arr_ack,
  input wire logic vec_req,
  input wire logic [1:0] vec_index,
  input wire logic vec_ack,
  input wire logic [15:0] vec_data,
  // Pins and status
  input wire logic boot_chip_select,
  input wire logic data_line_fourteen,
  input wire logic stop_mode
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [3:0] stop_cnt;
  logic [3:0] next_stop_cnt;
  logic win;
  logic rd_take;
  assign win = (arr_addr[23:5] == REG_BLOCK_BASE[23:5]);
  assign rd_take = arvalid && arready;
  always_comb begin
    next_stop_cnt = stop_cnt;
    if (!stop_mode) begin
      next_stop_cnt = 4'h0;
    end else if (stop_cnt != 4'hf) begin
      next_stop_cnt = stop_cnt + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_cnt <= 4'h0;
    end else begin
      stop_cnt <= next_stop_cnt;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_stop_refuse: assert property (
    stop_cnt == 4'hf && arr_req && !win |-> !arr_ack) else $error("array answered in stop");
  chk_window_fast: assert property (
    $rose(arr_req) && win |-> ##2 arr_ack) else $error("register window late");
  chk_ack_gap: assert property (
    $rose(arr_req) |=> !arr_ack) else $error("array answered too soon");
  chk_vec_word: assert property (
    !MASK_BOOT && vec_req && !vec_ack |=> vec_ack
      && vec_data == MASK_BOOT_WORDS[63 - 16 * $past(vec_index) -: 16])
    else $error("vector word wrong");
  chk_boot_select: assert property (
    boot_chip_select == MASK_BOOT && !(MASK_BOOT && vec_ack)) else $error("boot select wrong");
  chk_stop_load: assert property (
    $rose(aresetn) |=> stop_mode == !$past(data_line_fourteen, 4)) else $error("stop reset");
  chk_unimpl_zero: assert property (
    rd_take && araddr == 12'h01c |=> rvalid && rdata == 32'h0 && rresp == RESP_OKAY)
    else $error("unimplemented read");
  chk_rd_decerr: assert property (
    rd_take && araddr >= 12'h020 |=> rvalid && rresp == RESP_DECERR) else $error("decode");
  chk_sig_read: assert property (
    rd_take && araddr == 12'h004 |=> rdata[15:0] == MASK_SIG_HIGH) else $error("signature");
  chk_write_resp: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
  cover property (vec_ack);
  cover property (arr_ack && stop_mode);
  cover property (rvalid && rresp == RESP_DECERR);
endmodule

bind masked_rom_access_control masked_rom_access_control_properties #(
  .ADDR_W(ADDR_W), .MASK_BOOT(MASK_BOOT), .MASK_SIG_HIGH(MASK_SIG_HIGH),
  .MASK_BOOT_WORDS(MASK_BOOT_WORDS), .REG_BLOCK_BASE(REG_BLOCK_BASE)
) props (.*);

// ---- dv/masked_rom_access_control_tb.sv ----
// Self-checking bench for the masked ROM access control block
`timescale 1ns/1ps
module masked_rom_access_control_tb;
  import rom_module_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int LIM = 20;
  localparam logic [15:0] SIG_HI = 16'hc3a5;
  localparam logic [15:0] SIG_LO = 16'h0f1e;
  localparam logic [63:0] BOOT_W = 64'h1111_2222_3333_4444;
  localparam logic [31:0] REG_EXP [8] = '{32'h80c0, {16'h0, SIG_HI}, {16'h0, SIG_LO},
    32'h0, 32'h0, BOOT_W[63:32], BOOT_W[31:0], 32'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, arr_data;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, arr_size, vec_index;
  logic arr_req, arr_ack, arr_program, vec_req, vec_ack, boot_chip_select, stop_mode;
  logic [23:0] arr_addr;
  logic [15:0] vec_data;
  logic data_line_fourteen = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  int clk_of [4] = '{3, 4, 5, 2};
  always #20 aclk = ~aclk;
  masked_rom_access_control #(.MASK_SIG_HIGH(SIG_HI), .MASK_SIG_LOW(SIG_LO),
    .MASK_BOOT_WORDS(BOOT_W)) dut (.*);
  rom_bus_master_model bus (.*);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic give_up(input int n);
    if (n >= 40) begin
      num_errors++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      wrap_up();
    end
  endtask
  task automatic end_test(input string name);
    $display("Test done: %s, mismatches so far %0d", name, num_errors);
  endtask
  function automatic logic [15:0] rom_word(input logic [11:0] a);
    return {a[7:0], 4'h0, a[11:8]} ^ 16'h5a3c;
  endfunction
  task automatic do_reset(input logic line);
    @(posedge aclk);
    aresetn <= 1'b0;
    data_line_fourteen <= line;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    give_up(n);
    check(bresp, r, "write response");
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    give_up(n);
    check(rdata, d, "read data");
    check(rresp, r, "read response");
    rready <= 1'b0;
  endtask
  task automatic arr(input logic [23:0] a, input logic [1:0] s, input logic p, input int n_exp,
    input logic [31:0] d_exp);
    logic [31:0] d;
    logic [31:0] m;
    int n;
    m = (s == SIZE_LONG) ? 32'hffffffff : (s == SIZE_WORD) ? 32'h0000ffff : 32'h000000ff;
    bus.access(a, s, p, LIM, d, n);
    check(n, n_exp, "array cycles");
    if (n_exp < LIM) check(d & m, d_exp, "array data");
    if (n == LIM && n_exp < LIM) give_up(40);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] w3;
    logic [15:0] w4;
    logic [15:0] vd;
    int vn;
    w3 = rom_word(12'h003);
    w4 = rom_word(12'h004);
    do_reset(1'b0);
    for (int i = 0; i < 8; i++) begin
      axi_read(12'(4 * i), REG_EXP[i], RESP_OKAY);
    end
    axi_read(12'h020, 32'h0, RESP_DECERR);
    axi_write(12'h01c, 32'hffff, RESP_OKAY);
    axi_read(12'h01c, 32'h0, RESP_OKAY);
    check(boot_chip_select, 1'b0, "boot select");
    for (int i = 0; i < 4; i++) begin
      bus.vec_fetch(2'(i), vd, vn);
      check(vn, 2, "vector cycles");
      check(vd, BOOT_W[63 - 16 * i -: 16], "vector word");
    end
    end_test("reset state and vectors");
    arr(24'h000006, SIZE_BYTE, 1'b1, LIM, 32'h0);
    arr(24'hfff824, SIZE_WORD, 1'b0, 3, {16'h0, SIG_HI});
    axi_write(12'h010, 32'h2000, RESP_OKAY);
    axi_read(12'h010, 32'h2000, RESP_OKAY);
    axi_write(12'h000, 32'h00c0, RESP_OKAY);
    check(stop_mode, 1'b0, "stop mode");
    axi_write(12'h010, 32'h0000, RESP_OKAY);
    axi_read(12'h010, 32'h2000, RESP_OKAY);
    end_test("stop and base");
    for (int w = 0; w < 4; w++) begin
      axi_write(12'h000, {24'h0, 2'(w), 6'h0}, RESP_OKAY);
      arr(24'h002006, SIZE_BYTE, 1'b0, clk_of[w] + 1, {24'h0, w3[15:8]});
      arr(24'h002006, SIZE_LONG, 1'b0, 2 * clk_of[w] + 1, {w3, w4});
    end
    arr(24'h002007, SIZE_WORD, 1'b0, 5, {16'h0, w3[7:0], w4[15:8]});
    arr(24'h002006, SIZE_WORD, 1'b0, 3, {16'h0, w3});
    end_test("access timing");
    axi_write(12'h000, 32'h01c0, RESP_OKAY);
    arr(24'h002006, SIZE_BYTE, 1'b0, LIM, 32'h0);
    arr(24'h002006, SIZE_BYTE, 1'b1, 3, {24'h0, w3[15:8]});
    axi_write(12'h000, 32'h02c0, RESP_OKAY);
    arr(24'h002006, SIZE_BYTE, 1'b0, 3, {24'h0, w3[15:8]});
    end_test("address space");
    axi_write(12'h000, 32'h08c0, RESP_OKAY);
    axi_write(12'h000, 32'h0300, RESP_OKAY);
    axi_read(12'h000, 32'h08c0, RESP_OKAY);
    axi_write(12'h000, 32'h88c0, RESP_OKAY);
    axi_write(12'h010, 32'h4000, RESP_OKAY);
    axi_read(12'h010, 32'h2000, RESP_OKAY);
    arr(24'h002006, SIZE_BYTE, 1'b1, LIM, 32'h0);
    end_test("lock");
    do_reset(1'b1);
    axi_read(12'h000, 32'h00c0, RESP_OKAY);
    axi_read(12'h010, 32'h0000, RESP_OKAY);
    arr(24'h000006, SIZE_BYTE, 1'b0, 3, {24'h0, w3[15:8]});
    end_test("second reset");
    wrap_up();
  end
endmodule

// ---- dv/rom_bus_master_model.sv ----
// Bus master model for the array and reset vector ports
`timescale 1ns/1ps
module rom_bus_master_model (
  // Clock
  input wire logic aclk,
  // Array access port
  output logic arr_req,
  output logic [23:0] arr_addr,
  output logic [1:0] arr_size,
  output logic arr_program,
  input wire logic arr_ack,
  input wire logic [31:0] arr_data,
  // Reset vector port
  output logic vec_req,
  output logic [1:0] vec_index,
  input wire logic vec_ack,
  input wire logic [15:0] vec_data,
  input wire logic boot_chip_select
);
  initial begin
    arr_req = 1'b0;
    arr_addr = 24'h0;
    arr_size = 2'h0;
    arr_program = 1'b0;
    vec_req = 1'b0;
    vec_index = 2'h0;
  end
  // Holds the request until answered or the limit runs out
  task automatic access(input logic [23:0] a, input logic [1:0] s, input logic p,
    input int lim, output logic [31:0] d, output int n);
    n = 0;
    @(posedge aclk);
    arr_req <= 1'b1;
    arr_addr <= a;
    arr_size <= s;
    arr_program <= p;
    do begin
      @(posedge aclk);
      n++;
    end while (arr_ack !== 1'b1 && n < lim);
    d = arr_data;
    arr_req <= 1'b0;
    arr_addr <= ~a;
    arr_size <= ~s;
  endtask
  task automatic vec_fetch(input logic [1:0] i, output logic [15:0] d, output int n);
    n = 0;
    d = 16'h0;
    if (boot_chip_select !== 1'b0) begin // External boot memory serves instead
      return;
    end
    @(posedge aclk);
    vec_req <= 1'b1;
    vec_index <= i;
    do begin
      @(posedge aclk);
      n++;
    end while (vec_ack !== 1'b1 && n < 10);
    d = vec_data;
    vec_req <= 1'b0;
    vec_index <= ~i;
  endtask
endmodule

// ---- hdl/masked_rom_access_control.sv ----
// Masked ROM control: register slave, array access timing and boot vectors
`timescale 1ns/1ps
module masked_rom_access_control
  import rom_module_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic MASK_BOOT = 1'b0,
  parameter logic MASK_LOCK = 1'b0,
  parameter logic [1:0] MASK_ASP = 2'h0,
  parameter logic [1:0] MASK_WAIT = 2'h3,
  parameter logic [23:0] MASK_BASE = 24'h000000,
  parameter logic [15:0] MASK_SIG_HIGH = 16'h1234,
  parameter logic [15:0] MASK_SIG_LOW = 16'h5678,
  parameter logic [63:0] MASK_BOOT_WORDS = 64'h0000_0200_0000_0400,
  parameter logic [23:0] REG_BLOCK_BASE = 24'hfff820
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Array access port
  input wire logic arr_req,
  input wire logic [23:0] arr_addr,
  input wire logic [1:0] arr_size,
  input wire logic arr_program,
  output logic arr_ack,
  output logic [31:0] arr_data,
  // Reset vector port
  input wire logic vec_req,
  input wire logic [1:0] vec_index,
  output logic vec_ack,
  output logic [15:0] vec_data,
  output logic boot_chip_select,
  // Pins and status
  input wire logic data_line_fourteen,
  output logic stop_mode
);

  // ****************************************
  // Shared helpers
  // ****************************************
  function automatic logic [3:0] wait_clocks(input logic [1:0] w);
    case (w)
      WAIT_ZERO: wait_clocks = CLK_WAIT_ZERO;
      WAIT_ONE: wait_clocks = CLK_WAIT_ONE;
      WAIT_TWO: wait_clocks = CLK_WAIT_TWO;
      default: wait_clocks = CLK_WAIT_FAST;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic dl_s1;
  logic dl_s2;
  logic stop;
  logic lock;
  logic [1:0] asp;
  logic [1:0] wait_sel;
  logic [7:0] base_high;
  logic [2:0] base_low;
  logic [15:0] config_word;

  assign config_word = {stop, 2'h0, MASK_BOOT, lock, 1'b0, asp, wait_sel, 6'h0};

  function automatic logic [31:0] reg_read(input logic [4:0] off);
    case (off)
      OFF_CONFIG: reg_read = {16'h0, config_word};
      OFF_SIG_HIGH: reg_read = {16'h0, MASK_SIG_HIGH};
      OFF_SIG_LOW: reg_read = {16'h0, MASK_SIG_LOW};
      OFF_BASE_HIGH: reg_read = {24'h0, base_high};
      OFF_BASE_LOW: reg_read = {16'h0, base_low, 13'h0};
      OFF_BOOT_01: reg_read = MASK_BOOT_WORDS[63:32];
      OFF_BOOT_23: reg_read = MASK_BOOT_WORDS[31:0];
      default: reg_read = 32'h0;
    endcase
  endfunction

  // ****************************************
  // Data line fourteen synchroniser
  // ****************************************
  always_ff @(posedge aclk) begin
    dl_s1 <= data_line_fourteen;
    dl_s2 <= dl_s1;
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic aw_full;
  logic w_full;
  logic [4:0] wr_off;
  logic wr_in_block;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic next_aw_full;
  logic next_w_full;
  logic [4:0] next_wr_off;
  logic next_wr_in_block;
  logic [31:0] next_wr_data;
  logic [3:0] next_wr_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic wr_fire;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_wr_off = wr_off;
    next_wr_in_block = wr_in_block;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    wr_fire = 1'b0;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_wr_off = {awaddr[4:2], 2'h0};
      next_wr_in_block = (32'(awaddr) < BLOCK_BYTES);
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (aw_full && w_full && !bvalid) begin
      wr_fire = wr_in_block;
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_in_block ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_off <= 5'h0;
      wr_in_block <= 1'b0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      wr_off <= next_wr_off;
      wr_in_block <= next_wr_in_block;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      awready <= !next_aw_full && !next_bvalid;
      wready <= !next_w_full && !next_bvalid;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic next_stop;
  logic next_lock;
  logic [1:0] next_asp;
  logic [1:0] next_wait_sel;
  logic [7:0] next_base_high;
  logic [2:0] next_base_low;
  logic [15:0] cfg_new;
  logic [15:0] bl_new;

  always_comb begin
    next_stop = stop;
    next_lock = lock;
    next_asp = asp;
    next_wait_sel = wait_sel;
    next_base_high = base_high;
    next_base_low = base_low;
    cfg_new = merge16(config_word, wr_data, wr_strb);
    bl_new = merge16({base_low, 13'h0}, wr_data, wr_strb);
    if (wr_fire && wr_off == OFF_CONFIG) begin
      next_stop = cfg_new[POS_STOP];
      if (!lock) begin
        next_asp = cfg_new[POS_ASP +: 2];
        next_wait_sel = cfg_new[POS_WAIT +: 2];
        next_lock = cfg_new[POS_LOCK];
      end
    end
    if (wr_fire && stop && !lock) begin
      if (wr_off == OFF_BASE_HIGH && wr_strb[0]) begin
        next_base_high = wr_data[7:0];
      end
      if (wr_off == OFF_BASE_LOW) begin
        next_base_low = bl_new[15:13];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop <= !dl_s2;
      lock <= MASK_LOCK;
      asp <= MASK_ASP;
      wait_sel <= MASK_WAIT;
      base_high <= MASK_BASE[23:16];
      base_low <= MASK_BASE[15:13];
      stop_mode <= 1'b1;
    end else begin
      stop <= next_stop;
      lock <= next_lock;
      asp <= next_asp;
      wait_sel <= next_wait_sel;
      base_high <= next_base_high;
      base_low <= next_base_low;
      stop_mode <= next_stop;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  always_comb begin
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      if (32'(araddr) < BLOCK_BYTES) begin
        next_rdata = reg_read({araddr[4:2], 2'h0});
        next_rresp = RESP_OKAY;
      end else begin
        next_rdata = 32'h0;
        next_rresp = RESP_DECERR;
      end
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ****************************************
  // Array access sequencer
  // ****************************************
  acc_state_t acc_state;
  acc_state_t next_acc_state;
  logic [3:0] cnt;
  logic [3:0] total;
  logic [23:0] acc_addr;
  logic [1:0] acc_size;
  logic acc_reg;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic [3:0] next_cnt;
  logic [3:0] next_total;
  logic [23:0] next_acc_addr;
  logic [1:0] next_acc_size;
  logic next_acc_reg;
  logic [15:0] next_word_a;
  logic [15:0] next_word_b;
  logic next_arr_ack;
  logic [31:0] next_arr_data;
  logic mem_en;
  logic [11:0] mem_addr;
  logic [15:0] mem_data;
  logic reg_hit;
  logic arr_hit;
  logic space_ok;
  logic two_cycles;
  logic [15:0] wa;
  logic [15:0] wb;

  rom_array u_rom (
    .aclk(aclk),
    .rd_en(mem_en),
    .rd_addr(mem_addr),
    .rd_data(mem_data)
  );

  always_comb begin
    next_acc_state = acc_state;
    next_cnt = cnt;
    next_total = total;
    next_acc_addr = acc_addr;
    next_acc_size = acc_size;
    next_acc_reg = acc_reg;
    next_word_a = word_a;
    next_word_b = word_b;
    next_arr_ack = 1'b0;
    next_arr_data = arr_data;
    mem_en = 1'b0;
    mem_addr = arr_addr[12:1];
    reg_hit = (arr_addr[23:5] == REG_BLOCK_BASE[23:5]);
    arr_hit = (arr_addr[23:ARRAY_ADDR_BITS] == {base_high, base_low});
    space_ok = arr_program || !asp[0];
    two_cycles = (arr_size == SIZE_LONG) || (arr_size == SIZE_WORD && arr_addr[0]);
    wa = (cnt == 4'h1) ? mem_data : word_a;
    wb = (cnt == 4'h2) ? mem_data : word_b;
    case (acc_state)
      ACC_IDLE: begin
        if (arr_req && !arr_ack && reg_hit) begin
          next_acc_state = ACC_BUSY;
          next_acc_reg = 1'b1;
          next_total = CLK_REG_WINDOW;
          next_cnt = 4'h1;
          next_acc_addr = arr_addr;
        end else if (arr_req && !arr_ack && arr_hit && space_ok && !stop) begin
          next_acc_state = ACC_BUSY;
          next_acc_reg = 1'b0;
          next_acc_addr = arr_addr;
          next_acc_size = arr_size;
          next_cnt = 4'h1;
          mem_en = 1'b1;
          next_total = two_cycles ? 4'(wait_clocks(wait_sel) << 1)
                                  : wait_clocks(wait_sel);
        end
      end
      ACC_BUSY: begin
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == 4'h1) begin
          next_word_a = mem_data;
          mem_en = 1'b1;
          mem_addr = 12'(acc_addr[12:1] + 12'h1);
        end
        if (cnt == 4'h2) begin
          next_word_b = mem_data;
        end
        if (cnt == 4'(total - 4'h1)) begin
          next_acc_state = ACC_IDLE;
          next_arr_ack = 1'b1;
          if (acc_reg) begin
            next_arr_data = reg_read({acc_addr[4:2], 2'h0});
          end else begin
            case (acc_size)
              SIZE_BYTE: next_arr_data = {24'h0, acc_addr[0] ? wa[7:0] : wa[15:8]};
              SIZE_WORD: next_arr_data = acc_addr[0] ? {16'h0, wa[7:0], wb[15:8]}
                                                     : {16'h0, wa};
              default: next_arr_data = {wa, wb};
            endcase
          end
        end
      end
      default: next_acc_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_state <= ACC_IDLE;
      cnt <= 4'h0;
      total <= 4'h0;
      acc_addr <= 24'h0;
      acc_size <= SIZE_BYTE;
      acc_reg <= 1'b0;
      word_a <= 16'h0;
      word_b <= 16'h0;
      arr_ack <= 1'b0;
      arr_data <= 32'h0;
    end else begin
      acc_state <= next_acc_state;
      cnt <= next_cnt;
      total <= next_total;
      acc_addr <= next_acc_addr;
      acc_size <= next_acc_size;
      acc_reg <= next_acc_reg;
      word_a <= next_word_a;
      word_b <= next_word_b;
      arr_ack <= next_arr_ack;
      arr_data <= next_arr_data;
    end
  end

  // ****************************************
  // Reset vector supply
  // ****************************************
  logic next_vec_ack;
  logic [15:0] next_vec_data;

  always_comb begin
    next_vec_ack = 1'b0;
    next_vec_data = vec_data;
    if (vec_req && !vec_ack && !MASK_BOOT) begin
      next_vec_ack = 1'b1;
      next_vec_data = MASK_BOOT_WORDS[6'(7'd48 - 7'(vec_index) * 7'd16) +: 16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_ack <= 1'b0;
      vec_data <= 16'h0;
      boot_chip_select <= MASK_BOOT;
    end else begin
      vec_ack <= next_vec_ack;
      vec_data <= next_vec_data;
      boot_chip_select <= MASK_BOOT;
    end
  end

endmodule

// ---- hdl/rom_array.sv ----
// Mask-programmed array of 16-bit words with a registered read port
`timescale 1ns/1ps
module rom_array
  import rom_module_pkg::*;
#(
  parameter int WORDS = ARRAY_WORDS,
  parameter logic [15:0] PATTERN_SEED = 16'h5a3c
) (
  // Clock
  input wire logic aclk,
  // Read port
  input wire logic rd_en,
  input wire logic [11:0] rd_addr,
  output logic [15:0] rd_data
);

  // ****************************************
  // Fixed contents
  // ****************************************
  function automatic logic [15:0] mask_word(input logic [11:0] a);
    mask_word = {a[7:0], 4'h0, a[11:8]} ^ PATTERN_SEED;
  endfunction

  logic [15:0] next_rd_data;

  always_comb begin
    next_rd_data = rd_data;
    if (rd_en && (32'(rd_addr) < WORDS)) begin
      next_rd_data = mask_word(rd_addr);
    end
  end

  always_ff @(posedge aclk) begin
    rd_data <= next_rd_data;
  end

endmodule

// ---- inc/rom_module_pkg.sv ----
// Constants and types shared by the masked ROM access control design
package rom_module_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [4:0] OFF_CONFIG = 5'h00;
  localparam logic [4:0] OFF_SIG_HIGH = 5'h04;
  localparam logic [4:0] OFF_SIG_LOW = 5'h08;
  localparam logic [4:0] OFF_BASE_HIGH = 5'h0c;
  localparam logic [4:0] OFF_BASE_LOW = 5'h10;
  localparam logic [4:0] OFF_BOOT_01 = 5'h14;
  localparam logic [4:0] OFF_BOOT_23 = 5'h18;
  localparam int BLOCK_BYTES = 32;

  // ****************************************
  // Config register field positions
  // ****************************************
  localparam int POS_STOP = 15;
  localparam int POS_BOOT = 12;
  localparam int POS_LOCK = 11;
  localparam int POS_ASP = 8;
  localparam int POS_WAIT = 6;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ARRAY_ADDR_BITS = 13;
  localparam int ARRAY_WORDS = 4096;

  // ****************************************
  // Wait field codes and clocks per bus cycle
  // ****************************************
  localparam logic [1:0] WAIT_ZERO = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;
  localparam logic [1:0] WAIT_FAST = 2'h3;
  localparam logic [3:0] CLK_WAIT_ZERO = 4'h3;
  localparam logic [3:0] CLK_WAIT_ONE = 4'h4;
  localparam logic [3:0] CLK_WAIT_TWO = 4'h5;
  localparam logic [3:0] CLK_WAIT_FAST = 4'h2;
  localparam logic [3:0] CLK_REG_WINDOW = 4'h2;

  // ****************************************
  // Access sizes and bus answers
  // ****************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {ACC_IDLE, ACC_BUSY} acc_state_t;

endpackage
